/* File: pvcc_regs.svh */
// register offsets, field positions, reset values and counts for the pump and calibration bank
`ifndef PVCC_REGS_SVH
`define PVCC_REGS_SVH

// register indices; byte address is four times the index
`define PVCC_PUMP_IDX 4'h9
`define PVCC_CAL_IDX 4'ha

// reset values
`define PVCC_PUMP_RST 24'h403264
`define PVCC_CAL_RST 17'h02205

// pump register field positions (lsb)
`define PVCC_DN_LSB 0
`define PVCC_UP_LSB 7
`define PVCC_OFF_LSB 14
`define PVCC_OFF_UP_BIT 21
`define PVCC_OFF_DN_BIT 22
`define PVCC_HICP_BIT 23

// calibration register field positions (lsb)
`define PVCC_RES_LSB 0
`define PVCC_CURVE_LSB 3
`define PVCC_WAIT_LSB 6
`define PVCC_SAR_LSB 8
`define PVCC_FORCE_BIT 10
`define PVCC_BYPASS_BIT 11
`define PVCC_NOTRIG_BIT 12
`define PVCC_CLKSEL_LSB 13
`define PVCC_FALL_BIT 15
`define PVCC_RDIVBYP_BIT 16

// current steps in microamps and other counts
`define PVCC_GAIN_STEP_UA 12'h014
`define PVCC_OFF_STEP_UA 10'h005
`define PVCC_WAIT_PERIODS 7'h64
`define PVCC_SAR_MAX 4'h8

`endif

/* File: pvcc_pkg.sv */
// types for the pump and calibration configuration bank
package pvcc_pkg;

    // pump register layout, msb first
    typedef struct packed {
        logic high_current_pump;
        logic off_dn_en;
        logic off_up_en;
        logic [6:0] off_mag;
        logic [6:0] up_gain;
        logic [6:0] dn_gain;
    } pvcc_pump_s;

    // calibration register layout, msb first
    typedef struct packed {
        logic force_rdiv_bypass;
        logic ref_fall_edge;
        logic [1:0] clk_sel;
        logic no_serial_trigger;
        logic bypass_tuning;
        logic force_curve;
        logic [1:0] sar_code;
        logic [1:0] wait_code;
        logic [2:0] curve_adj;
        logic [2:0] meas_code;
    } pvcc_cal_s;

    // decoded controls toward the pump and calibration engine
    typedef struct packed {
        logic [11:0] dn_ua;
        logic [11:0] up_ua;
        logic [9:0] off_ua;
        logic off_up_en;
        logic off_dn_en;
        logic high_current_pump;
        logic [8:0] meas_cycles;
        logic [3:0] curve_shift;
        logic [1:0] wait_after;
        logic [6:0] wait_periods;
        logic [3:0] sar_bits;
        logic auto_tune_en;
        logic force_curve;
        logic force_rdiv_bypass;
    } pvcc_drive_s;

    // calibration clock divider ratio codes
    typedef enum logic [1:0] {
        PVCC_DIV1 = 2'b00,
        PVCC_DIV4 = 2'b01,
        PVCC_DIV16 = 2'b10,
        PVCC_DIV32 = 2'b11
    } pvcc_div_e;

endpackage

/* File: pvcc_ahb_slave.sv */
// ahb-lite slave front end for the configuration bank
`timescale 1ns/1ps
`include "pvcc_regs.svh"
module pvcc_ahb_slave
    import pvcc_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 32
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [DATA_W-1:0] hrdata,
    output logic wr_pump,
    output logic wr_cal,
    input wire logic [23:0] pump_next,
    input wire logic [16:0] cal_next
);
    logic wr_pump_reg;
    logic wr_cal_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic take;
    logic [ADDR_W-3:0] idx;

    // elaboration check on the bus widths
    if (DATA_W != 32 || ADDR_W < 6) begin
        $error("pvcc_ahb_slave: unsupported bus widths");
    end

    // address phase accepted on a nonseq or seq transfer
    assign take = hsel && htrans[1] && hready;
    assign idx = haddr[ADDR_W-1:2];

    // write strobes held for the data phase
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_pump_reg <= 1'b0;
            wr_cal_reg <= 1'b0;
        end else begin
            wr_pump_reg <= take && hwrite && (idx == (ADDR_W-2)'(`PVCC_PUMP_IDX));
            wr_cal_reg <= take && hwrite && (idx == (ADDR_W-2)'(`PVCC_CAL_IDX));
        end
    end

    // read data captured from next register values; unmapped reads zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 32'h0;
        end else if (take && !hwrite) begin
            if (idx == (ADDR_W-2)'(`PVCC_PUMP_IDX)) begin
                rdata_reg <= {8'h0, pump_next};
            end else if (idx == (ADDR_W-2)'(`PVCC_CAL_IDX)) begin
                rdata_reg <= {15'h0, cal_next};
            end else begin
                rdata_reg <= 32'h0;
            end
        end
    end

    // zero wait states, always okay; hsize is accepted as a word
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;
    assign wr_pump = wr_pump_reg;
    assign wr_cal = wr_cal_reg;
endmodule

/* File: pvcc_decode.sv */
// decodes stored fields into physical pump and calibration settings
`timescale 1ns/1ps
`include "pvcc_regs.svh"
module pvcc_decode
    import pvcc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire pvcc_pump_s pump,
    input wire pvcc_cal_s cal,
    output pvcc_drive_s drive
);
    pvcc_drive_s drive_reg;
    pvcc_drive_s drive_next;

    // combinational field decode
    always_comb begin
        drive_next = '0;
        drive_next.dn_ua = {5'h0, pump.dn_gain} * `PVCC_GAIN_STEP_UA; // R01
        drive_next.up_ua = {5'h0, pump.up_gain} * `PVCC_GAIN_STEP_UA; // R02
        drive_next.off_ua = {3'h0, pump.off_mag} * `PVCC_OFF_STEP_UA; // R03
        drive_next.off_up_en = pump.off_up_en; // R04
        drive_next.off_dn_en = pump.off_dn_en; // R05
        drive_next.high_current_pump = pump.high_current_pump; // R06
        case (cal.meas_code) // R07
            3'h0: drive_next.meas_cycles = 9'h001;
            3'h1: drive_next.meas_cycles = 9'h002;
            3'h2: drive_next.meas_cycles = 9'h004;
            3'h3: drive_next.meas_cycles = 9'h008;
            3'h4: drive_next.meas_cycles = 9'h020;
            3'h5: drive_next.meas_cycles = 9'h040;
            3'h6: drive_next.meas_cycles = 9'h080;
            default: drive_next.meas_cycles = 9'h100;
        endcase
        // codes 4..7 are -4..-1: sign extension of the 3-bit code
        drive_next.curve_shift = {cal.curve_adj[2], cal.curve_adj}; // R08
        drive_next.wait_after = cal.wait_code; // R09
        drive_next.wait_periods = `PVCC_WAIT_PERIODS; // R09
        drive_next.sar_bits = `PVCC_SAR_MAX - {2'h0, cal.sar_code}; // R10
        drive_next.auto_tune_en = !cal.bypass_tuning; // R11
        drive_next.force_curve = cal.force_curve;
        drive_next.force_rdiv_bypass = cal.force_rdiv_bypass;
    end

    // registered outputs
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            drive_reg <= '0;
        end else begin
            drive_reg <= drive_next;
        end
    end

    assign drive = drive_reg;
endmodule

/* File: pvcc_top.sv */
// pump current and oscillator calibration configuration bank with ahb-lite access
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "pvcc_regs.svh"
// Notes on behaviour
// R01: down gain bits 6:0, 20 uA per code, resets to 100.
// R02: up gain bits 13:7, 20 uA per code, resets to 100.
// R03: offset magnitude bits 20:14, 5 uA per code, resets to zero.
// R04: bit 21 enables upward offset current, resets to 0.
// R05: bit 22 enables downward offset current, resets to 1.
// R06: bit 23 selects high-current pump, resets to 0.
// R07: bits 2:0 pick measurement length 1..256 reference cycles, reset 5.
// R08: bits 5:3 shift selected curve by +0..+3 or -4..-1.
// R09: bits 7:6 add 100-period waits after the first 0..3 measurements.
// R10: bits 9:8 set search depth of 8, 7, 6 or 5 bits.
// R11: bit 11 bypasses automatic tuning; cleared selects curve by calibration.
// R12: bit 12 suppresses serial transfers to the oscillator subsystem.
// R13: bits 14:13 divide reference by 1, 4, 16 or 32, reset 1.
// R14: bit 15 runs calibration timing on falling reference edge.
// R15: reset loads printed defaults; written fields read back unchanged.
module pvcc_top
    import pvcc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic ref_in,
    input wire logic osc_reg_write,
    output logic osc_serial_start,
    output logic cal_tick,
    output pvcc_drive_s drive
);
    pvcc_pump_s pump_reg;
    pvcc_pump_s pump_next;
    pvcc_cal_s cal_reg;
    pvcc_cal_s cal_next;
    logic wr_pump;
    logic wr_cal;
    logic ref_meta_reg;
    logic ref_sync_reg;
    logic ref_prev_reg;
    logic ref_edge;
    logic [4:0] div_cnt_reg;
    logic [4:0] div_last;
    logic cal_tick_reg;
    logic osc_start_reg;

    // elaboration check on the address width
    if (ADDR_W < 6) begin
        $error("pvcc_top: address too narrow for the register map");
    end

    ////////////////////////////////////////////////////////////////////////
    // bus front end

    pvcc_ahb_slave #(
        .ADDR_W(ADDR_W),
        .DATA_W(32)
    ) u_bus (
        .clock(clock),
        .rst_n(rst_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .wr_pump(wr_pump),
        .wr_cal(wr_cal),
        .pump_next(pump_next),
        .cal_next(cal_next)
    );

    ////////////////////////////////////////////////////////////////////////
    // configuration registers

    // next values: data phase write takes the low bits of hwdata
    assign pump_next = wr_pump ? pvcc_pump_s'(hwdata[23:0]) : pump_reg; // R15
    assign cal_next = wr_cal ? pvcc_cal_s'(hwdata[16:0]) : cal_reg; // R15

    // pump register, all fields r/w
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pump_reg <= `PVCC_PUMP_RST; // R01
        end else begin
            pump_reg <= pump_next; // R02
        end
    end

    // calibration register, bits 31:17 read as zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cal_reg <= `PVCC_CAL_RST; // R07
        end else begin
            cal_reg <= cal_next; // R13
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // field decode toward pump and calibration engine

    // gains, offset, offset enables, high current, wait and sar decode
    pvcc_decode u_dec (
        .clock(clock),
        .rst_n(rst_n),
        .pump(pump_reg), // R03
        .cal(cal_reg), // R11
        .drive(drive) // R06
    );

    ////////////////////////////////////////////////////////////////////////
    // calibration clock from the reference pin

    // two-flop synchroniser, then edge history
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ref_meta_reg <= 1'b0;
            ref_sync_reg <= 1'b0;
            ref_prev_reg <= 1'b0;
        end else begin
            ref_meta_reg <= ref_in;
            ref_sync_reg <= ref_meta_reg;
            ref_prev_reg <= ref_sync_reg;
        end
    end

    // edge choice: rising normally, falling when selected
    assign ref_edge = cal_reg.ref_fall_edge ? (ref_prev_reg && !ref_sync_reg) // R14
                                            : (!ref_prev_reg && ref_sync_reg);

    // divider terminal count per ratio code
    always_comb begin
        case (pvcc_div_e'(cal_reg.clk_sel))
            PVCC_DIV1: div_last = 5'h00; // R13
            PVCC_DIV4: div_last = 5'h03;
            PVCC_DIV16: div_last = 5'h0f;
            PVCC_DIV32: div_last = 5'h1f;
            default: div_last = 5'h00;
        endcase
    end

    // divider counter; a ratio change mid-count ends at the new limit
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_reg <= 5'h00;
            cal_tick_reg <= 1'b0;
        end else begin
            cal_tick_reg <= ref_edge && (div_cnt_reg >= div_last); // R13
            if (ref_edge) begin
                div_cnt_reg <= (div_cnt_reg >= div_last) ? 5'h00 : div_cnt_reg + 5'h01;
            end
        end
    end

    assign cal_tick = cal_tick_reg;

    ////////////////////////////////////////////////////////////////////////
    // oscillator serial trigger gating

    // a write to the oscillator register starts a transfer unless inhibited
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            osc_start_reg <= 1'b0;
        end else begin
            osc_start_reg <= osc_reg_write && !cal_reg.no_serial_trigger; // R12
        end
    end

    assign osc_serial_start = osc_start_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_pump_write;
        hsel && htrans[1] && hready && hwrite
            && (haddr[ADDR_W-1:2] == (ADDR_W-2)'(`PVCC_PUMP_IDX));
    endsequence

    sequence s_cal_read;
        hsel && htrans[1] && hready && !hwrite && !wr_cal
            && (haddr[ADDR_W-1:2] == (ADDR_W-2)'(`PVCC_CAL_IDX));
    endsequence

    sequence s_pump_read;
        hsel && htrans[1] && hready && !hwrite && !wr_pump
            && (haddr[ADDR_W-1:2] == (ADDR_W-2)'(`PVCC_PUMP_IDX));
    endsequence

    sequence s_cal_write;
        hsel && htrans[1] && hready && hwrite
            && (haddr[ADDR_W-1:2] == (ADDR_W-2)'(`PVCC_CAL_IDX));
    endsequence

    AST_PUMP_WRITE: assert property ( // R15
        s_pump_write ##1 1'b1 |=> (pump_reg == $past(hwdata[23:0]))
    ) else $error("pump register did not take written data");

    AST_CAL_READ: assert property ( // R15
        s_cal_read |=> (hrdata == {15'h0, $past(cal_reg)})
    ) else $error("calibration register readback mismatch");

    AST_DN_UA: assert property ( // R01
        rst_n |=> (drive.dn_ua == {5'h0, $past(pump_reg.dn_gain)} * 12'h014)
    ) else $error("down current not 20 uA per code");

    AST_UP_UA: assert property ( // R02
        rst_n |=> (drive.up_ua == {5'h0, $past(pump_reg.up_gain)} * 12'h014)
    ) else $error("up current not 20 uA per code");

    AST_OFF_UA: assert property ( // R03
        rst_n |=> (drive.off_ua == {3'h0, $past(pump_reg.off_mag)} * 10'h005)
    ) else $error("offset current not 5 uA per code");

    AST_PUMP_BITS: assert property ( // R06
        rst_n |=> (drive.high_current_pump == $past(pump_reg.high_current_pump))
            && (drive.off_dn_en == $past(pump_reg.off_dn_en))
            && (drive.off_up_en == $past(pump_reg.off_up_en))
    ) else $error("pump enable bits not passed through");

    AST_MEAS: assert property ( // R07
        (cal_reg.meas_code == 3'h7) |=> (drive.meas_cycles == 9'h100)
    ) else $error("measurement length code 7 not 256 cycles");

    AST_CURVE: assert property ( // R08
        (cal_reg.curve_adj == 3'h4) |=> (drive.curve_shift == 4'hc)
    ) else $error("curve code 4 not minus four");

    AST_WAIT: assert property ( // R09
        rst_n |=> (drive.wait_periods == 7'h64) && (drive.wait_after == $past(cal_reg.wait_code))
    ) else $error("wait setup decode wrong");

    AST_SAR: assert property ( // R10
        rst_n |=> (drive.sar_bits == 4'h8 - {2'h0, $past(cal_reg.sar_code)})
    ) else $error("search depth decode wrong");

    AST_BYPASS: assert property ( // R11
        cal_reg.bypass_tuning |=> !drive.auto_tune_en
    ) else $error("tuning bypass not honoured");

    AST_INHIBIT: assert property ( // R12
        osc_reg_write |=> (osc_serial_start == !$past(cal_reg.no_serial_trigger))
    ) else $error("oscillator serial trigger gating wrong");

    AST_TICK_DIV: assert property ( // R13
        cal_tick |-> $past(ref_edge) && ($past(div_cnt_reg) >= $past(div_last))
    ) else $error("calibration tick without divider terminal count");

    AST_DIV4_GAP: assert property ( // R13
        (pvcc_div_e'(cal_reg.clk_sel) == PVCC_DIV4) && $stable(cal_reg) && cal_tick
            |-> (div_cnt_reg == 5'h00)
    ) else $error("divider not restarted after tick");

    AST_FALL: assert property ( // R14
        cal_tick && $past(cal_reg.ref_fall_edge) |-> $past(ref_prev_reg) && !$past(ref_sync_reg)
    ) else $error("falling edge selection not honoured");

    AST_PUMP_READ: assert property ( // R15
        s_pump_read |=> (hrdata == {8'h0, $past(pump_reg)})
    ) else $error("pump register readback mismatch");

    AST_CAL_WRITE: assert property ( // R15
        s_cal_write ##1 1'b1 |=> (cal_reg == $past(hwdata[16:0]))
    ) else $error("calibration register did not take written data");

    AST_RESET_DEFAULTS: assert property ( // R15
        $rose(rst_n) |-> (pump_reg == `PVCC_PUMP_RST) && (cal_reg == `PVCC_CAL_RST)
    ) else $error("registers not at defaults after reset");

    AST_OFF_UP: assert property ( // R04
        rst_n |=> (drive.off_up_en == $past(pump_reg.off_up_en))
    ) else $error("upward offset enable not passed through");

    AST_OFF_DN: assert property ( // R05
        rst_n |=> (drive.off_dn_en == $past(pump_reg.off_dn_en))
    ) else $error("downward offset enable not passed through");

    AST_OSC_IDLE: assert property ( // R12
        !osc_reg_write |=> !osc_serial_start
    ) else $error("oscillator serial start without a register write");

    AST_TICK_ONE: assert property ( // R13
        cal_tick |=> !cal_tick
    ) else $error("calibration tick longer than one cycle");

    AST_NO_TICK: assert property ( // R13
        !ref_edge |=> !cal_tick
    ) else $error("calibration tick without a reference edge");
endmodule

/* File: tb_pump_and_vco_cal_config.sv */
// self-checking bench for the pump current and calibration configuration bank
`timescale 1ns/1ps
module tb_pump_and_vco_cal_config
    import pvcc_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic ref_in = 1'b0;
    logic osc_reg_write = 1'b0;
    logic osc_serial_start;
    logic cal_tick;
    pvcc_drive_s drive;
    int miscompares = 0;
    int samples_checked = 0;
    int tick_cnt = 0;
    logic [31:0] pump_val = 32'h00403264;

    ////////////////////////////////////////////////////////////////////////////////
    // device under test, bus ready fed back from the slave
    pvcc_top #(.ADDR_W(8)) i_dut (
        .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ref_in(ref_in),
        .osc_reg_write(osc_reg_write), .osc_serial_start(osc_serial_start),
        .cal_tick(cal_tick), .drive(drive)
    );

    // 20 mhz clock
    initial begin
        forever #25 clock = ~clock;
    end

    // tally of calibration ticks
    always @(posedge clock) begin
        if (cal_tick === 1'b1) tick_cnt <= tick_cnt + 1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one single ahb-lite transfer, entered just after a rising edge
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        rd = hrdata;
        chk({71'h0, hresp}, 72'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        ahb(1'b1, a, d, dummy);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] got;
        ahb(1'b0, a, 32'h00000000, got);
        chk(72'(got), 72'(exp));
    endtask

    function automatic pvcc_drive_s exp_drive(input pvcc_pump_s p, input pvcc_cal_s c);
        pvcc_drive_s d;
        d.dn_ua = 12'(p.dn_gain) * 12'h014;
        d.up_ua = 12'(p.up_gain) * 12'h014;
        d.off_ua = 10'(p.off_mag) * 10'h005;
        d.off_up_en = p.off_up_en;
        d.off_dn_en = p.off_dn_en;
        d.high_current_pump = p.high_current_pump;
        if (c.meas_code < 3'h4) d.meas_cycles = 9'h001 << c.meas_code;
        else d.meas_cycles = 9'h001 << (4'(c.meas_code) + 4'h1);
        d.curve_shift = {c.curve_adj[2], c.curve_adj};
        d.wait_after = c.wait_code;
        d.wait_periods = 7'h64;
        d.sar_bits = 4'h8 - {2'b00, c.sar_code};
        d.auto_tune_en = ~c.bypass_tuning;
        d.force_curve = c.force_curve;
        d.force_rdiv_bypass = c.force_rdiv_bypass;
        return d;
    endfunction

    // drive follows the register one edge after the write lands
    task automatic chk_drive(input logic [31:0] p, input logic [31:0] c);
        repeat (2) @(posedge clock);
        #1;
        chk(72'(drive), 72'(exp_drive(p[23:0], c[16:0])));
        @(posedge clock);
    endtask

    // reference pin pulses, four clocks high and four low
    task automatic ref_pulses(input int n);
        repeat (n) begin
            ref_in <= 1'b1;
            repeat (4) @(posedge clock);
            ref_in <= 1'b0;
            repeat (4) @(posedge clock);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_defaults();
        rd(8'h24, 32'h00403264);
        rd(8'h28, 32'h00002205);
        chk_drive(32'h00403264, 32'h00002205);
        pump_val = 32'h00403264;
    endtask

    task automatic t_pump();
        logic [31:0] vals [3];
        vals = '{32'hffffffff, 32'h00000000, 32'h00a5c3e1};
        foreach (vals[i]) begin
            wr(8'h24, vals[i]);
            rd(8'h24, vals[i] & 32'h00ffffff);
            chk_drive(vals[i], 32'h00002205);
        end
        pump_val = 32'h00a5c3e1;
    endtask

    task automatic t_cal();
        pvcc_cal_s c;
        for (int i = 0; i < 8; i++) begin
            c = '0;
            c.meas_code = 3'(i);
            c.curve_adj = 3'(i);
            c.wait_code = 2'(i);
            c.sar_code = 2'(7 - i);
            c.force_curve = i[0];
            c.bypass_tuning = i[1];
            c.clk_sel = 2'(i);
            c.force_rdiv_bypass = i[2];
            wr(8'h28, 32'(c));
            rd(8'h28, 32'(c));
            chk_drive(pump_val, 32'(c));
        end
        wr(8'h28, 32'hffffffff);
        rd(8'h28, 32'h0001ffff);
    endtask

    task automatic t_unmapped();
        wr(8'h2c, 32'hffffffff);
        rd(8'h2c, 32'h00000000);
        wr(8'h20, 32'hffffffff);
        rd(8'h20, 32'h00000000);
        rd(8'h24, pump_val);
    endtask

    task automatic t_osc(input logic [31:0] cal, input logic exp);
        wr(8'h28, cal);
        osc_reg_write <= 1'b1;
        @(posedge clock);
        osc_reg_write <= 1'b0;
        #1;
        chk({71'h0, osc_serial_start}, {71'h0, exp});
        @(posedge clock);
        #1;
        chk({71'h0, osc_serial_start}, 72'h0);
        @(posedge clock);
    endtask

    task automatic t_divider();
        int sh;
        int base;
        for (int s = 0; s < 4; s++) begin
            sh = (s == 0) ? 0 : (s == 1) ? 2 : (s == 2) ? 4 : 5;
            wr(8'h28, 32'h00000205 | (s << 13));
            ref_pulses(32);
            base = tick_cnt;
            ref_pulses(32);
            chk(72'(tick_cnt - base), 72'(32 >> sh));
        end
    endtask

    // divide by one: ticks follow the chosen reference edge
    task automatic t_edge(input logic fall);
        int base;
        wr(8'h28, 32'h00000205 | (32'(fall) << 15));
        ref_pulses(2);
        // let a tick from the last falling edge be tallied first
        @(posedge clock);
        base = tick_cnt;
        ref_in <= 1'b1;
        repeat (6) @(posedge clock);
        chk(72'(tick_cnt - base), 72'(!fall));
        base = tick_cnt;
        ref_in <= 1'b0;
        repeat (6) @(posedge clock);
        chk(72'(tick_cnt - base), 72'(fall));
    endtask

    task automatic t_reset();
        rst_n <= 1'b0;
        repeat (6) @(posedge clock);
        chk(72'(drive), 72'h0);
        rst_n <= 1'b1;
        @(posedge clock);
        t_defaults();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_defaults();
        t_pump();
        t_cal();
        t_unmapped();
        t_osc(32'h00002205, 1'b1);
        t_osc(32'h00003205, 1'b0);
        t_osc(32'h00002205, 1'b1);
        t_divider();
        t_edge(1'b0);
        t_edge(1'b1);
        t_reset();
        wrap_up();
    end

    // watchdog well beyond the expected run of about 2300 cycles
    initial begin
        #(20000 * 50);
        miscompares++;
        wrap_up();
    end
endmodule
